// ==== src/lms_top.sv ====
// Notes on behaviour
// - One load mode bit: 0 constant current (default), 1 constant power.
// - Status word mirrors the load mode in a read-only flag.
// - Current mode, select 0: previous discharge cycle average current.
// - Current mode, select 0 without a recorded previous cycle uses present average current.
// - Current mode, select 1 (default): average current since this discharge began.
// - Select 2 uses mean current; select 3 its 14 s low-pass version.
// - Current mode, select 4: design capacity divided by 5.
// - Current mode, select 6: user current rate.
// - Power mode, select 0: previous discharge cycle average power.
// - Power mode, select 1: average power since this discharge began.
// - Select 2: mean current times voltage; select 3: filtered current times voltage.
// - Power mode: select 4 design energy over 5; select 6 user power rate.
// - Reserve charge and reserve energy settings held for the two remaining values.
// - One bit picks loaded or no-load rate for reserve compensation.
// - Scale above 1 multiplies energy, reserve energy and power units.
// - Discharge is detected when current exceeds a configurable threshold.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "lms_cfg.svh"
module lms_top
#(
    parameter int SAMPLE_CYCLES = `LMS_SAMPLE_MS * `LMS_CLK_KHZ
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic signed [15:0] mean_current_in,
    input wire logic [15:0] voltage_in,
    output logic [31:0] load_rate_out,
    output logic load_model_status_flag_out,
    output logic discharging_out,
    output logic [15:0] reserve_charge_out,
    output logic [31:0] reserve_energy_out,
    output logic reserve_rate_select_out,
    output logic [31:0] reserve_comp_rate_out,
    output logic [31:0] design_energy_out,
    output logic [3:0] energy_scale_out,
    output logic sample_tick_out
);
    import lms_pkg::*;

    localparam logic [23:0] TICK_LAST = 24'(SAMPLE_CYCLES - 1);

    lms_state_t s;
    lms_state_t next_s;
    logic tick;
    logic [15:0] dsg_mag;
    logic dsg_now;
    logic [31:0] p_inst;
    logic [31:0] p_filt;
    logic [15:0] lpf_i;
    logic [3:0] scale_eff;
    logic [31:0] rate;
    logic div_start;
    logic [31:0] quo_i;
    logic [31:0] quo_p;
    logic done_i;
    logic done_p;
    logic addr_ok;
    logic wr_en;
    logic [31:0] rd_word;
    logic [32:0] sum_i_add;
    logic [32:0] sum_p_add;

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
    endfunction

    function automatic logic [31:0] scaled(input logic [15:0] v, input logic [3:0] k);
        scaled = 32'(v) * 32'(k);
    endfunction

    // Dividers for the running averages of the present discharge cycle
    lms_div u_div_current
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(div_start),
        .num_in(s.sum_i),
        .den_in(32'(s.cnt)),
        .quo_out(quo_i),
        .done_out(done_i)
    );

    // Dividing by count times scale leaves the power average in scaled units
    lms_div u_div_power
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(div_start),
        .num_in(s.sum_p),
        .den_in(32'(s.cnt) * 32'(scale_eff)),
        .quo_out(quo_p),
        .done_out(done_p)
    );

    lms_lpf u_lpf
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .sample_in(dsg_mag),
        .filtered_out(lpf_i)
    );

    always_comb
    begin
        // Out-of-range scale is clamped so the units never collapse to zero
        if (s.scale < `LMS_SCALE_MIN)
        begin
            scale_eff = `LMS_SCALE_MIN;
        end
        else if (s.scale > `LMS_SCALE_MAX)
        begin
            scale_eff = `LMS_SCALE_MAX;
        end
        else
        begin
            scale_eff = s.scale;
        end
    end

    assign tick = (s.tick_cnt == TICK_LAST);
    // Discharge current is negative; charging contributes nothing
    assign dsg_mag = mean_current_in[15] ? 16'(-mean_current_in) : 16'h0000;
    assign dsg_now = (dsg_mag > s.dsg_threshold);
    assign p_inst = (32'(dsg_mag) * 32'(voltage_in)) / 32'(`LMS_MILLI_DIV);
    assign p_filt = (32'(lpf_i) * 32'(voltage_in)) / 32'(`LMS_MILLI_DIV);
    assign div_start = tick && s.discharging && (s.cnt != 16'h0000);
    assign sum_i_add = {1'b0, s.sum_i} + 33'(dsg_mag);
    assign sum_p_add = {1'b0, s.sum_p} + 33'(p_inst);

    always_comb
    begin
        rate = 32'h0;
        if (!s.load_mode)
        begin
            unique case (s.load_select)
                `LMS_SEL_LAST_RUN:
                begin
                    rate = s.last_valid ? 32'(s.avg_i_last) : 32'(s.avg_i_now);
                end
                `LMS_SEL_MEAN:
                begin
                    rate = 32'(dsg_mag);
                end
                `LMS_SEL_FILTERED:
                begin
                    rate = 32'(lpf_i);
                end
                `LMS_SEL_DESIGN_FIFTH:
                begin
                    rate = 32'(s.design_cap) / 32'(`LMS_CRATE_DIV);
                end
                `LMS_SEL_USER:
                begin
                    rate = 32'(s.user_current_rate);
                end
                default:
                begin
                    rate = 32'(s.avg_i_now);
                end
            endcase
        end
        else
        begin
            unique case (s.load_select)
                `LMS_SEL_PRESENT_RUN:
                begin
                    rate = scaled(s.avg_p_now, scale_eff);
                end
                `LMS_SEL_MEAN:
                begin
                    rate = p_inst;
                end
                `LMS_SEL_FILTERED:
                begin
                    rate = p_filt;
                end
                `LMS_SEL_DESIGN_FIFTH:
                begin
                    rate = scaled(s.design_energy, scale_eff) / 32'(`LMS_CRATE_DIV);
                end
                `LMS_SEL_USER:
                begin
                    rate = scaled(s.user_power_rate, scale_eff);
                end
                default:
                begin
                    rate = scaled(s.avg_p_last, scale_eff);
                end
            endcase
        end
    end

    always_comb
    begin
        addr_ok = 1'b1;
        rd_word = 32'h0;
        unique case (paddr_in)
            `LMS_ADDR_CONFIG:
            begin
                rd_word[`LMS_CFG_LOAD_MODE_BIT] = s.load_mode;
                rd_word[`LMS_CFG_SELECT_LSB +: 3] = s.load_select;
                rd_word[`LMS_CFG_RESERVE_SEL_BIT] = s.reserve_rate_select;
                rd_word[`LMS_CFG_SCALE_LSB +: 4] = s.scale;
            end
            `LMS_ADDR_STATUS:
            begin
                rd_word[`LMS_STS_LOAD_MODE_BIT] = s.load_mode;
                rd_word[`LMS_STS_DISCHARGING_BIT] = s.discharging;
                rd_word[`LMS_STS_LAST_VALID_BIT] = s.last_valid;
            end
            `LMS_ADDR_DESIGN_CAPACITY: rd_word = 32'(s.design_cap);
            `LMS_ADDR_DESIGN_ENERGY: rd_word = 32'(s.design_energy);
            `LMS_ADDR_USER_CURRENT_RATE: rd_word = 32'(s.user_current_rate);
            `LMS_ADDR_USER_POWER_RATE: rd_word = 32'(s.user_power_rate);
            `LMS_ADDR_RESERVE_CHARGE: rd_word = 32'(s.reserve_charge);
            `LMS_ADDR_RESERVE_ENERGY: rd_word = 32'(s.reserve_energy);
            `LMS_ADDR_DSG_THRESHOLD: rd_word = 32'(s.dsg_threshold);
            `LMS_ADDR_AVG_I_LAST: rd_word = 32'(s.avg_i_last);
            `LMS_ADDR_AVG_P_LAST: rd_word = 32'(s.avg_p_last);
            `LMS_ADDR_LOAD_RATE: rd_word = s.load_rate;
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_en = psel_in && penable_in && pwrite_in && addr_ok;

    always_comb
    begin
        next_s = s;
        next_s.tick_cnt = tick ? 24'h0 : s.tick_cnt + 24'h1;
        next_s.load_rate = rate;
        // Read data is captured in the setup cycle so prdata comes from a flop
        if (psel_in && !penable_in)
        begin
            next_s.prdata = rd_word;
        end
        if (wr_en)
        begin
            unique case (paddr_in)
                `LMS_ADDR_CONFIG:
                begin
                    next_s.load_mode = pwdata_in[`LMS_CFG_LOAD_MODE_BIT];
                    next_s.load_select = pwdata_in[`LMS_CFG_SELECT_LSB +: 3];
                    next_s.reserve_rate_select = pwdata_in[`LMS_CFG_RESERVE_SEL_BIT];
                    next_s.scale = pwdata_in[`LMS_CFG_SCALE_LSB +: 4];
                end
                `LMS_ADDR_DESIGN_CAPACITY: next_s.design_cap = pwdata_in[15:0];
                `LMS_ADDR_DESIGN_ENERGY: next_s.design_energy = pwdata_in[15:0];
                `LMS_ADDR_USER_CURRENT_RATE: next_s.user_current_rate = pwdata_in[15:0];
                `LMS_ADDR_USER_POWER_RATE: next_s.user_power_rate = pwdata_in[15:0];
                `LMS_ADDR_RESERVE_CHARGE: next_s.reserve_charge = pwdata_in[15:0];
                `LMS_ADDR_RESERVE_ENERGY: next_s.reserve_energy = pwdata_in[15:0];
                `LMS_ADDR_DSG_THRESHOLD: next_s.dsg_threshold = pwdata_in[15:0];
                default:
                begin
                end
            endcase
        end
        if (done_i)
        begin
            next_s.avg_i_now = sat16(quo_i);
        end
        if (done_p)
        begin
            next_s.avg_p_now = sat16(quo_p);
        end
        if (tick)
        begin
            next_s.discharging = dsg_now;
            if (dsg_now && !s.discharging)
            begin
                next_s.sum_i = 32'(dsg_mag);
                next_s.sum_p = p_inst;
                next_s.cnt = 16'h0001;
                next_s.avg_i_now = dsg_mag;
                next_s.avg_p_now = 16'h0000;
            end
            else if (dsg_now)
            begin
                // Accumulators saturate rather than wrap on very long cycles
                next_s.sum_i = sum_i_add[32] ? 32'hFFFFFFFF : sum_i_add[31:0];
                next_s.sum_p = sum_p_add[32] ? 32'hFFFFFFFF : sum_p_add[31:0];
                next_s.cnt = (s.cnt == 16'hFFFF) ? s.cnt : s.cnt + 16'h1;
            end
            else if (s.discharging)
            begin
                next_s.avg_i_last = s.avg_i_now;
                next_s.avg_p_last = s.avg_p_now;
                next_s.last_valid = 1'b1;
                next_s.sum_i = 32'h0;
                next_s.sum_p = 32'h0;
                next_s.cnt = 16'h0000;
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            s <= '0;
            s.load_mode <= `LMS_RST_LOAD_MODE;
            s.load_select <= `LMS_RST_LOAD_SELECT;
            s.reserve_rate_select <= `LMS_RST_RESERVE_SEL;
            s.scale <= `LMS_RST_SCALE;
            s.design_cap <= `LMS_RST_DESIGN_CAPACITY;
            s.design_energy <= `LMS_RST_DESIGN_ENERGY;
            s.user_current_rate <= `LMS_RST_USER_RATE;
            s.user_power_rate <= `LMS_RST_USER_RATE;
            s.reserve_charge <= `LMS_RST_RESERVE;
            s.reserve_energy <= `LMS_RST_RESERVE;
            s.dsg_threshold <= `LMS_RST_DSG_THRESHOLD;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;
    assign load_rate_out = s.load_rate;
    assign load_model_status_flag_out = s.load_mode;
    assign discharging_out = s.discharging;
    assign reserve_charge_out = s.reserve_charge;
    assign reserve_energy_out = scaled(s.reserve_energy, scale_eff);
    assign reserve_rate_select_out = s.reserve_rate_select;
    // No-load compensation is modelled as a zero rate
    assign reserve_comp_rate_out = s.reserve_rate_select ? 32'h0 : s.load_rate;
    assign design_energy_out = scaled(s.design_energy, scale_eff);
    assign energy_scale_out = scale_eff;
    assign sample_tick_out = tick;
endmodule // lms_top

// ==== src/lms_cfg.svh ====
`ifndef LMS_CFG_SVH
`define LMS_CFG_SVH

// Register byte offsets on the APB bus
`define LMS_ADDR_CONFIG 12'h000
`define LMS_ADDR_STATUS 12'h004
`define LMS_ADDR_DESIGN_CAPACITY 12'h008
`define LMS_ADDR_DESIGN_ENERGY 12'h00C
`define LMS_ADDR_USER_CURRENT_RATE 12'h010
`define LMS_ADDR_USER_POWER_RATE 12'h014
`define LMS_ADDR_RESERVE_CHARGE 12'h018
`define LMS_ADDR_RESERVE_ENERGY 12'h01C
`define LMS_ADDR_DSG_THRESHOLD 12'h020
`define LMS_ADDR_AVG_I_LAST 12'h024
`define LMS_ADDR_AVG_P_LAST 12'h028
`define LMS_ADDR_LOAD_RATE 12'h02C

// Field positions in the configuration word
`define LMS_CFG_LOAD_MODE_BIT 0
`define LMS_CFG_SELECT_LSB 4
`define LMS_CFG_RESERVE_SEL_BIT 8
`define LMS_CFG_SCALE_LSB 12

// Field positions in the status word
`define LMS_STS_LOAD_MODE_BIT 0
`define LMS_STS_DISCHARGING_BIT 1
`define LMS_STS_LAST_VALID_BIT 2

// Reset values
`define LMS_RST_LOAD_MODE 1'h0
`define LMS_RST_LOAD_SELECT 3'h1
`define LMS_RST_RESERVE_SEL 1'h0
`define LMS_RST_SCALE 4'h1
`define LMS_RST_DESIGN_CAPACITY 16'h03E8
`define LMS_RST_DESIGN_ENERGY 16'h0E10
`define LMS_RST_USER_RATE 16'h0000
`define LMS_RST_RESERVE 16'h0000
`define LMS_RST_DSG_THRESHOLD 16'h003C

// Load selection codes
`define LMS_SEL_LAST_RUN 3'h0
`define LMS_SEL_PRESENT_RUN 3'h1
`define LMS_SEL_MEAN 3'h2
`define LMS_SEL_FILTERED 3'h3
`define LMS_SEL_DESIGN_FIFTH 3'h4
`define LMS_SEL_USER 3'h6

// Scale limits and arithmetic constants
`define LMS_SCALE_MIN 4'h1
`define LMS_SCALE_MAX 4'hA
`define LMS_CRATE_DIV 5
`define LMS_MILLI_DIV 1000

// Timing
`define LMS_CLK_KHZ 10000
`define LMS_SAMPLE_MS 1000
`define LMS_LPF_TAU_S 14

`endif

// ==== src/lms_pkg.sv ====
package lms_pkg;

    typedef enum logic [0:0] {
        LMS_DIV_IDLE = 1'b0,
        LMS_DIV_RUN = 1'b1
    } lms_div_phase_t;

    typedef struct packed {
        lms_div_phase_t phase;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] den;
        logic [5:0] bit_cnt;
        logic done;
    } lms_div_t;

    typedef struct packed {
        logic [23:0] acc;
    } lms_lpf_t;

    typedef struct packed {
        logic load_mode;
        logic [2:0] load_select;
        logic reserve_rate_select;
        logic [3:0] scale;
        logic [15:0] design_cap;
        logic [15:0] design_energy;
        logic [15:0] user_current_rate;
        logic [15:0] user_power_rate;
        logic [15:0] reserve_charge;
        logic [15:0] reserve_energy;
        logic [15:0] dsg_threshold;
        logic [23:0] tick_cnt;
        logic discharging;
        logic last_valid;
        logic [31:0] sum_i;
        logic [31:0] sum_p;
        logic [15:0] cnt;
        logic [15:0] avg_i_now;
        logic [15:0] avg_p_now;
        logic [15:0] avg_i_last;
        logic [15:0] avg_p_last;
        logic [31:0] load_rate;
        logic [31:0] prdata;
    } lms_state_t;

endpackage

// ==== src/lms_div.sv ====
`timescale 1ns/1ps
// Restoring divider, one quotient bit per clock
module lms_div
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [31:0] num_in,
    input wire logic [31:0] den_in,
    output logic [31:0] quo_out,
    output logic done_out
);
    import lms_pkg::*;

    lms_div_t s;
    lms_div_t next_s;
    logic [32:0] trial;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        trial = {s.rem, s.quo[31]};
        unique case (s.phase)
            LMS_DIV_IDLE:
            begin
                if (start_in)
                begin
                    next_s.phase = LMS_DIV_RUN;
                    next_s.rem = 32'h0;
                    next_s.quo = num_in;
                    next_s.den = den_in;
                    next_s.bit_cnt = 6'h20;
                end
            end
            LMS_DIV_RUN:
            begin
                if (trial >= {1'b0, s.den})
                begin
                    next_s.rem = 32'(trial - {1'b0, s.den});
                    next_s.quo = {s.quo[30:0], 1'b1};
                end
                else
                begin
                    next_s.rem = trial[31:0];
                    next_s.quo = {s.quo[30:0], 1'b0};
                end
                next_s.bit_cnt = s.bit_cnt - 6'h1;
                if (s.bit_cnt == 6'h1)
                begin
                    next_s.phase = LMS_DIV_IDLE;
                    next_s.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign quo_out = s.quo;
    assign done_out = s.done;
endmodule // lms_div

// ==== src/lms_lpf.sv ====
`timescale 1ns/1ps
`include "lms_cfg.svh"
// First-order low-pass filter, eight fraction bits kept to avoid a dead band
module lms_lpf
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic [15:0] sample_in,
    output logic [15:0] filtered_out
);
    import lms_pkg::*;

    localparam int TAU_SAMPLES = (`LMS_LPF_TAU_S * 1000) / `LMS_SAMPLE_MS;

    lms_lpf_t s;
    lms_lpf_t next_s;
    logic signed [25:0] diff;

    always_comb
    begin
        next_s = s;
        diff = $signed({2'b00, sample_in, 8'h00}) - $signed({2'b00, s.acc});
        if (tick_in)
        begin
            next_s.acc = 24'($signed({2'b00, s.acc}) + diff / 26'(TAU_SAMPLES));
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign filtered_out = s.acc[23:8];
endmodule // lms_lpf

// ==== verification/lms_top_monitor.sv ====
`timescale 1ns/1ps
`include "lms_cfg.svh"
module lms_top_monitor
#(
    parameter int SAMPLE_CYCLES = 64
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic signed [15:0] mean_current_in,
    input wire logic [31:0] load_rate_out,
    input wire logic load_model_status_flag_out,
    input wire logic discharging_out,
    input wire logic [15:0] reserve_charge_out,
    input wire logic reserve_rate_select_out,
    input wire logic [31:0] reserve_comp_rate_out,
    input wire logic [31:0] design_energy_out,
    input wire logic [3:0] energy_scale_out,
    input wire logic sample_tick_out
);
    logic wr_cfg;
    logic wr_rsv;
    logic seen_tick;
    logic [31:0] since_tick;
    assign wr_cfg = psel_in && penable_in && pwrite_in && paddr_in == `LMS_ADDR_CONFIG;
    assign wr_rsv = psel_in && penable_in && pwrite_in && paddr_in == `LMS_ADDR_RESERVE_CHARGE;
    // Period is judged from the second tick on, the first tick's phase after reset is free
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            seen_tick <= 1'b0;
            since_tick <= 32'h0;
        end
        else
        begin
            seen_tick <= seen_tick || sample_tick_out;
            since_tick <= sample_tick_out ? 32'h1 : since_tick + 32'h1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_mode_write: assert property (wr_cfg |=> load_model_status_flag_out == $past(pwdata_in[0]))
        else $error("load mode flag does not follow config write");
    a_mode_hold: assert property (!wr_cfg |=> $stable(load_model_status_flag_out))
        else $error("load mode flag changed without config write");
    a_scale_write: assert property (wr_cfg |=> energy_scale_out == ($past(pwdata_in[15:12]) == 4'h0 ? 4'h1 :
        $past(pwdata_in[15:12]) > 4'hA ? 4'hA : $past(pwdata_in[15:12]))) else $error("scale not taken");
    a_scale_range: assert property (energy_scale_out >= 4'h1 && energy_scale_out <= 4'hA)
        else $error("effective scale out of range");
    a_energy_multiple: assert property (psel_in && penable_in && pwrite_in &&
        paddr_in == `LMS_ADDR_DESIGN_ENERGY |=> design_energy_out == $past(pwdata_in[15:0]) * energy_scale_out)
        else $error("design energy not scaled");
    a_rsel_write: assert property (wr_cfg |=> reserve_rate_select_out == $past(pwdata_in[8]))
        else $error("reserve rate select not taken");
    a_comp_rate: assert property (reserve_comp_rate_out == (reserve_rate_select_out ? 32'h0 : load_rate_out))
        else $error("reserve compensation rate wrong");
    a_reserve_write: assert property (wr_rsv |=> reserve_charge_out == $past(pwdata_in[15:0]))
        else $error("reserve charge not taken");
    a_dsg_charge: assert property (sample_tick_out && mean_current_in >= 0 |=> !discharging_out)
        else $error("discharge flagged without discharge current");
    a_dsg_timing: assert property ($changed(discharging_out) |-> $past(sample_tick_out))
        else $error("discharge flag moved off a tick");
    a_tick_period: assert property (sample_tick_out && seen_tick |-> since_tick == SAMPLE_CYCLES)
        else $error("sample tick period wrong");
endmodule // lms_top_monitor

bind lms_top lms_top_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_lms_top_monitor (.clock_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .mean_current_in, .load_rate_out, .load_model_status_flag_out,
    .discharging_out, .reserve_charge_out, .reserve_rate_select_out, .reserve_comp_rate_out, .design_energy_out,
    .energy_scale_out, .sample_tick_out);

// ==== verification/test_load_model_selector.sv ====
`timescale 1ns/1ps
`include "lms_cfg.svh"
module test_load_model_selector;
    logic clock_in, rst_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, load_rate_out, reserve_energy_out, reserve_comp_rate_out, design_energy_out;
    logic signed [15:0] mean_current_in;
    logic [15:0] voltage_in, reserve_charge_out;
    logic pready_out, pslverr_out, load_model_status_flag_out, discharging_out, reserve_rate_select_out;
    logic sample_tick_out;
    logic [3:0] energy_scale_out;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 29056;

    lms_top #(.SAMPLE_CYCLES(64)) u_lms_top (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .mean_current_in, .voltage_in, .load_rate_out,
        .load_model_status_flag_out, .discharging_out, .reserve_charge_out, .reserve_energy_out,
        .reserve_rate_select_out, .reserve_comp_rate_out, .design_energy_out, .energy_scale_out, .sample_tick_out);

    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    function automatic logic [31:0] eff(input logic [3:0] s);
        return s == 4'h0 ? 32'h1 : s > 4'hA ? 32'hA : {28'h0, s};
    endfunction

    function automatic logic [31:0] pwr(input logic [15:0] i, input logic [15:0] v);
        return i * v / 1000;
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [32:0] exp, input logic [32:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // A cycle passes before each setup so back-to-back calls never drive a signal twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        q = {pslverr_out, prdata_out};
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk($sformatf("read %h", a), exp, q);
    endtask

    task automatic ticks(input int n);
        repeat (n)
            do @(posedge clock_in); while (sample_tick_out !== 1'b1);
        repeat (40) @(posedge clock_in);
    endtask

    // Forty cycles cover the divider as well as the one-cycle select latency
    task automatic lr(input logic m, input logic [2:0] sl, input logic [3:0] sc, input logic rs, input logic [31:0] exp);
        wr(`LMS_ADDR_CONFIG, {16'h0, sc, 3'h0, rs, 1'h0, sl, 3'h0, m});
        repeat (40) @(posedge clock_in);
        chk("load_rate", exp, load_rate_out);
        chk("comp_rate", rs ? 32'h0 : exp, reserve_comp_rate_out);
        chk("mode_flag", m, load_model_status_flag_out);
    endtask

    initial
    begin
        repeat (30000) @(posedge clock_in);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        logic [15:0] c, e, u, p, r, ia, ib, v;
        logic [3:0] s;
        logic [31:0] k, pa;
        rst_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        mean_current_in = 16'sh0;
        voltage_in = 16'h0;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(`LMS_ADDR_CONFIG, 33'h0_0000_1010);
        rd(`LMS_ADDR_DESIGN_CAPACITY, 33'h0_0000_03E8);
        rd(`LMS_ADDR_DSG_THRESHOLD, 33'h0_0000_003C);
        wr(`LMS_ADDR_STATUS, 32'hFFFF_FFFF);
        rd(`LMS_ADDR_STATUS, 33'h0);
        rd(12'h030, 33'h1_0000_0000);
        for (int i = 0; i < 12; i++)
        begin
            s = 4'(i % 10 + 1);
            k = eff(s);
            c = 16'($random(seed));
            e = 16'(($random(seed) & 32'hFFF) * 5);
            u = 16'($random(seed));
            p = 16'($random(seed) & 32'hFFF);
            r = 16'($random(seed));
            wr(`LMS_ADDR_DESIGN_CAPACITY, {16'h0, c});
            wr(`LMS_ADDR_DESIGN_ENERGY, {16'h0, e});
            wr(`LMS_ADDR_USER_CURRENT_RATE, {16'h0, u});
            wr(`LMS_ADDR_USER_POWER_RATE, {16'h0, p});
            wr(`LMS_ADDR_RESERVE_CHARGE, {16'h0, r});
            wr(`LMS_ADDR_RESERVE_ENERGY, {16'h0, r});
            lr(1'b0, 3'h4, s, i[0], c / 5);
            lr(1'b0, 3'h6, s, i[0], u);
            lr(1'b1, 3'h4, s, i[0], e * k / 5);
            lr(1'b1, 3'h6, s, i[0], p * k);
            chk("design_energy", e * k, design_energy_out);
            chk("reserve_energy", r * k, reserve_energy_out);
            chk("reserve_charge", r, reserve_charge_out);
            chk("scale", k, energy_scale_out);
        end
        ia = 16'(100 + ($random(seed) & 32'h1FF));
        v = 16'(3000 + ($random(seed) & 32'h7FF));
        pa = pwr(ia, v);
        lr(1'b0, 3'h1, 4'h1, 1'b0, 32'h0);
        mean_current_in <= -ia;
        voltage_in <= v;
        ticks(3);
        chk("discharging", 1, discharging_out);
        lr(1'b0, 3'h1, 4'h1, 1'b0, ia);
        lr(1'b0, 3'h0, 4'h1, 1'b0, ia);
        lr(1'b0, 3'h7, 4'h1, 1'b0, ia);
        lr(1'b0, 3'h2, 4'h1, 1'b0, ia);
        lr(1'b1, 3'h2, 4'h1, 1'b0, pa);
        lr(1'b1, 3'h1, 4'h1, 1'b0, pa);
        wr(`LMS_ADDR_DSG_THRESHOLD, {16'h0, ia});
        ticks(1);
        chk("discharging", 0, discharging_out);
        rd(`LMS_ADDR_AVG_I_LAST, {17'h0, ia});
        rd(`LMS_ADDR_AVG_P_LAST, {1'b0, pa});
        rd(`LMS_ADDR_STATUS, 33'h0_0000_0005);
        wr(`LMS_ADDR_DSG_THRESHOLD, 32'h0000_003C);
        ib = 16'(ia + 16'h0064);
        mean_current_in <= -ib;
        ticks(3);
        lr(1'b0, 3'h0, 4'h1, 1'b0, ia);
        lr(1'b1, 3'h0, 4'h1, 1'b0, pa);
        lr(1'b1, 3'h5, 4'h1, 1'b0, pa);
        lr(1'b1, 3'h1, 4'h1, 1'b0, pwr(ib, v));
        give_verdict();
    end
endmodule // test_load_model_selector
